// *** hw/osc_tune_pkg.sv ***
// Overview of operation
// - self_tune_enable set: hardware calibration drives the trim field
// - tune_halt_in_idle set: tuning pauses while the core is idle
// - reference select: one picks usb frame timing, zero the 32.768 kHz crystal
// - lock status reads one while error stays within plus or minus 0.2 percent
// - lock polarity one flags lack of lock, zero flags lock
// - out-of-range set when error exceeds trim reach; tuning then stops
// - range polarity one flags in-range, zero flags out-of-range
// - trim is signed: 011111 highest, 100000 lowest, zero is centre
// - software writes to trim ignored while self-tune is enabled
// - bit 14 and bits 7 to 6 of tune register read zero
// - switching allowed only when switch_monitor_config is zero
// - switching disabled: next source ignored, active source shows configured default
// - switching disabled: switch request has no effect and reads zero
// - switching enabled: software moves among the four sources any time
// - primary submode fixed by configuration; requests for src_primary_pll are refused, requests for src_primary are taken
// - self-tune irq flag raised on lock or range condition per polarity
// - usb reference uses start-of-frame pulses from the host
package osc_tune_pkg;
   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [7:0] tune_addr     = 8'h00;
   localparam logic [7:0] control_addr  = 8'h04;
   localparam logic [7:0] status_addr   = 8'h08;
   localparam logic [7:0] mask_addr     = 8'h0c;
   localparam logic [7:0] measure_addr  = 8'h10;
   // tune register fields
   localparam int         enable_bit    = 15;
   localparam int         halt_bit      = 13;
   localparam int         ref_bit       = 12;
   localparam int         lock_bit      = 11;
   localparam int         lpol_bit      = 10;
   localparam int         range_bit     = 9;
   localparam int         rpol_bit      = 8;
   localparam logic [15:0] tune_rw_mask = 16'hb53f;
   localparam logic [15:0] tune_reset   = 16'h0000;
   // oscillator source codes
   localparam logic [2:0] src_fast_rc   = 3'h0;
   localparam logic [2:0] src_primary   = 3'h2;
   localparam logic [2:0] src_primary_pll = 3'h3;
   localparam logic [2:0] src_secondary = 3'h4;
   localparam logic [2:0] src_low_power = 3'h5;
   localparam logic [2:0] src_reserved  = 3'h6;
   // lock tolerance in parts per thousand: 0.2 percent
   localparam int         lock_tol_ppt  = 2;
   // status bits: lock irq, range irq, switch done
   localparam int         n_events      = 3;
   // axi responses
   localparam logic [1:0] resp_okay     = 2'h0;
   localparam logic [1:0] resp_slverr   = 2'h2;

   typedef struct packed {
      logic        enable;
      logic        halt_idle;
      logic        ref_usb;
      logic        lock_pol;
      logic        range_pol;
   } tune_ctrl_t;

   typedef struct packed {
      logic        lock;
      logic        range;
   } tune_stat_t;
endpackage

// *** hw/trim_tuner.sv ***
module trim_tuner
   import osc_tune_pkg::*;
#(
   parameter int cnt_w = 16
)(
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire tune_ctrl_t       ctrl,
   input  wire logic             idle,
   input  wire logic             ref_tick,
   input  wire logic             rc_tick,
   input  wire logic [cnt_w-1:0] expected,
   input  wire logic [cnt_w-1:0] span,
   input  wire logic [5:0]       sw_trim,
   output      logic [5:0]       trim,
   output      tune_stat_t       stat,
   output      logic [cnt_w-1:0] last_count
);
   logic [cnt_w-1:0] count_reg;
   logic [cnt_w-1:0] err;
   logic             fast;
   logic             run;
   logic [cnt_w+9:0] tol;

   assign run  = ctrl.enable && !(ctrl.halt_idle && idle);
   assign fast = count_reg > expected;
   assign err  = fast ? count_reg - expected : expected - count_reg;
   // tolerance scaled by 1000 to stay in integers
   assign tol  = (cnt_w+10)'(expected) * (cnt_w+10)'(lock_tol_ppt);

   // count rc ticks per reference period
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count_reg  <= '0;
         last_count <= '0;
      end else if (!run) begin
         count_reg <= '0;
      end else if (ref_tick) begin
         count_reg  <= '0;
         last_count <= count_reg;
      end else if (rc_tick) begin
         count_reg <= count_reg + 1'b1;
      end
   end

   // status update once per reference period
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stat <= '0;
      end else if (!ctrl.enable) begin
         stat <= '0;
      end else if (run && ref_tick) begin
         stat.lock  <= ((cnt_w+10)'(err) * (cnt_w+10)'(1000)) <= tol;
         stat.range <= err > span && ((fast && trim == 6'h20) || (!fast && trim == 6'h1f));
      end
   end

   // trim stepping, one lsb per period
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         trim <= '0;
      end else if (!ctrl.enable) begin
         // software owns trim only when disabled
         trim <= sw_trim;
      end else if (run && ref_tick && !stat.range && err != '0) begin
         if (fast && trim != 6'h20)
            trim <= trim - 1'b1;
         else if (!fast && trim != 6'h1f)
            trim <= trim + 1'b1;
      end
   end
endmodule

// *** hw/source_switch.sv ***
module source_switch
   import osc_tune_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       monitor_cfg,
   input  wire logic [2:0] default_src,
   input  wire logic [2:0] next_src,
   input  wire logic       req_set,
   output      logic [2:0] active_src,
   output      logic       req,
   output      logic       done
);
   logic       enabled;
   logic       loaded_reg;
   logic       valid;

   // switching only when config bit is zero
   assign enabled = !monitor_cfg;
   // pll submode refused, plain primary allowed; reserved refused
   assign valid   = next_src != src_reserved && next_src != src_primary_pll;

   // active source follows config while disabled
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         active_src <= src_fast_rc;
         loaded_reg <= 1'b0;
         req        <= 1'b0;
         done       <= 1'b0;
      end else begin
         done <= 1'b0;
         if (!loaded_reg || !enabled) begin
            active_src <= default_src;
            loaded_reg <= 1'b1;
            req        <= 1'b0;
         end else if (req) begin
            if (valid)
               active_src <= next_src;
            req  <= 1'b0;
            done <= valid && next_src != active_src;
         end else if (req_set) begin
            req <= 1'b1;
         end
      end
   end
endmodule

// *** hw/osc_tune_top.sv ***
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
module osc_tune_top
   import osc_tune_pkg::*;
#(
   parameter int cnt_w = 16
)(
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [7:0]       s_axi_awaddr,
   input  wire logic             s_axi_awvalid,
   output      logic             s_axi_awready,
   input  wire logic [31:0]      s_axi_wdata,
   input  wire logic [3:0]       s_axi_wstrb,
   input  wire logic             s_axi_wvalid,
   output      logic             s_axi_wready,
   output      logic [1:0]       s_axi_bresp,
   output      logic             s_axi_bvalid,
   input  wire logic             s_axi_bready,
   input  wire logic [7:0]       s_axi_araddr,
   input  wire logic             s_axi_arvalid,
   output      logic             s_axi_arready,
   output      logic [31:0]      s_axi_rdata,
   output      logic [1:0]       s_axi_rresp,
   output      logic             s_axi_rvalid,
   input  wire logic             s_axi_rready,
   input  wire logic             switch_monitor_config,
   input  wire logic [2:0]       default_source_config,
   input  wire logic             idle,
   input  wire logic             usb_sof_pin,
   input  wire logic             crystal_tick_pin,
   input  wire logic             rc_tick_pin,
   output      logic [5:0]       freq_trim_field,
   output      logic [2:0]       active_source_field,
   output      logic             self_tune_irq_flag,
   output      logic             irq
);
   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   logic [2:0] sync_reg [3];
   logic [2:0] pins;
   logic [2:0] stable_reg;
   logic [2:0] rise;
   assign pins = {usb_sof_pin, crystal_tick_pin, rc_tick_pin};

   // three stages; change accepted once stage two and three agree
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_sync
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               sync_reg[g]   <= '0;
               stable_reg[g] <= 1'b0;
            end else begin
               sync_reg[g] <= {sync_reg[g][1:0], pins[g]};
               if (sync_reg[g][1] == sync_reg[g][2])
                  stable_reg[g] <= sync_reg[g][2];
            end
         end
         assign rise[g] = sync_reg[g][1] == sync_reg[g][2] && sync_reg[g][2] && !stable_reg[g];
      end
   endgenerate

   // ****************************************************************
   // registers
   // ****************************************************************
   tune_ctrl_t       ctrl;
   tune_stat_t       stat;
   logic [15:0]      tune_reg;
   logic [5:0]       sw_trim_reg;
   logic [2:0]       next_src_reg;
   logic             req_set;
   logic             req;
   logic             sw_done;
   logic [n_events-1:0] status_reg;
   logic [n_events-1:0] mask_reg;
   logic [n_events-1:0] events;
   logic [cnt_w-1:0] expected_reg;
   logic [cnt_w-1:0] span_reg;
   logic [cnt_w-1:0] last_count;
   logic             ref_tick;

   assign ref_tick = ctrl.ref_usb ? rise[2] : rise[1];

   trim_tuner #(.cnt_w(cnt_w)) u_tuner (
      .clk        (clk),
      .rst        (rst),
      .ctrl       (ctrl),
      .idle       (idle),
      .ref_tick   (ref_tick),
      .rc_tick    (rise[0]),
      .expected   (expected_reg),
      .span       (span_reg),
      .sw_trim    (sw_trim_reg),
      .trim       (freq_trim_field),
      .stat       (stat),
      .last_count (last_count)
   );

   source_switch u_switch (
      .clk         (clk),
      .rst         (rst),
      .monitor_cfg (switch_monitor_config),
      .default_src (default_source_config),
      .next_src    (next_src_reg),
      .req_set     (req_set),
      .active_src  (active_source_field),
      .req         (req),
      .done        (sw_done)
   );

   // unused positions read zero; status from hardware only
   always_comb begin
      tune_reg                = '0;
      tune_reg[enable_bit]    = ctrl.enable;
      tune_reg[halt_bit]      = ctrl.halt_idle;
      tune_reg[ref_bit]       = ctrl.ref_usb;
      tune_reg[lock_bit]      = stat.lock;
      tune_reg[lpol_bit]      = ctrl.lock_pol;
      tune_reg[range_bit]     = stat.range;
      tune_reg[rpol_bit]      = ctrl.range_pol;
      tune_reg[5:0]           = freq_trim_field;
   end

   // irq flag per polarity; polarity ignored while disabled
   assign self_tune_irq_flag = ctrl.enable &&
      ((stat.lock ^ ctrl.lock_pol) || (stat.range ^ ctrl.range_pol));

   // ****************************************************************
   // axi4-lite slave
   // ****************************************************************
   logic [7:0]  awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0]  wstrb_reg;
   logic        aw_have_reg;
   logic        w_have_reg;
   logic        do_write;
   logic        hit;
   logic [31:0] rdata_next;
   logic        rhit;

   // ready low while an item is held, so only one write is ever in flight
   assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
   assign s_axi_wready  = !w_have_reg && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign do_write      = aw_have_reg && w_have_reg && !s_axi_bvalid;
   assign hit = awaddr_reg inside {tune_addr, control_addr, status_addr, mask_addr, measure_addr};

   // capture address and data in either order
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         aw_have_reg <= 1'b0;
         w_have_reg  <= 1'b0;
         awaddr_reg  <= '0;
         wdata_reg   <= '0;
         wstrb_reg   <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= resp_okay;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_have_reg  <= 1'b0;
            w_have_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= hit ? resp_okay : resp_slverr;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // writable control state
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl         <= '0;
         sw_trim_reg  <= tune_reset[5:0];
         next_src_reg <= src_fast_rc;
         mask_reg     <= '0;
         expected_reg <= '0;
         span_reg     <= '0;
         req_set      <= 1'b0;
      end else begin
         req_set <= 1'b0;
         if (do_write && awaddr_reg == tune_addr) begin
            if (wstrb_reg[1]) begin
               ctrl.enable    <= wdata_reg[enable_bit];
               ctrl.halt_idle <= wdata_reg[halt_bit];
               ctrl.ref_usb   <= wdata_reg[ref_bit];
               ctrl.lock_pol  <= wdata_reg[lpol_bit];
               ctrl.range_pol <= wdata_reg[rpol_bit];
            end
            // trim write dropped while self-tune runs
            if (wstrb_reg[0] && !ctrl.enable)
               sw_trim_reg <= wdata_reg[5:0];
         end
         if (do_write && awaddr_reg == control_addr && wstrb_reg[0]) begin
            // next source only matters when switching enabled
            next_src_reg <= wdata_reg[6:4];
            req_set      <= wdata_reg[0];
         end
         if (do_write && awaddr_reg == mask_addr && wstrb_reg[0])
            mask_reg <= wdata_reg[n_events-1:0];
         if (do_write && awaddr_reg == measure_addr) begin
            if (wstrb_reg[1:0] == 2'h3)
               expected_reg <= wdata_reg[cnt_w-1:0];
            if (wstrb_reg[3:2] == 2'h3)
               span_reg <= wdata_reg[cnt_w+15:16];
         end
      end
   end

   // ****************************************************************
   // interrupts: sticky status, write one to clear, set wins
   // ****************************************************************
   logic lock_irq_reg;
   logic range_irq_reg;
   // previous level, so only a fresh condition counts as an event
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lock_irq_reg  <= 1'b0;
         range_irq_reg <= 1'b0;
      end else begin
         lock_irq_reg  <= ctrl.enable && (stat.lock ^ ctrl.lock_pol);
         range_irq_reg <= ctrl.enable && (stat.range ^ ctrl.range_pol);
      end
   end
   // lock polarity; range polarity; rising edges only
   assign events = {sw_done,
                    ctrl.enable && (stat.range ^ ctrl.range_pol) && !range_irq_reg,
                    ctrl.enable && (stat.lock ^ ctrl.lock_pol) && !lock_irq_reg};

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         status_reg <= '0;
      end else begin
         if (do_write && awaddr_reg == status_addr && wstrb_reg[0])
            status_reg <= (status_reg & ~wdata_reg[n_events-1:0]) | events;
         else
            status_reg <= status_reg | events;
      end
   end
   assign irq = |(status_reg & mask_reg);

   // read path
   always_comb begin
      rdata_next = '0;
      rhit       = 1'b1;
      case (s_axi_araddr)
         tune_addr:    rdata_next[15:0] = tune_reg;
         // request reads zero while switching disabled
         control_addr: rdata_next = {20'h0, 1'b0, active_source_field, 1'b0,
                                     next_src_reg, 3'h0, req && !switch_monitor_config};
         status_addr:  rdata_next[n_events-1:0] = status_reg;
         mask_addr:    rdata_next[n_events-1:0] = mask_reg;
         measure_addr: rdata_next = {span_reg, last_count};
         default:      rhit = 1'b0;
      endcase
   end

   // read data latched with rvalid, so it stands until rready is seen
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= resp_okay;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rdata_next;
         s_axi_rresp  <= rhit ? resp_okay : resp_slverr;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   trim_locked_a: assert property (
      ctrl.enable && do_write && awaddr_reg == tune_addr |=> $stable(sw_trim_reg))
      else $error("trim shadow changed while self-tune enabled");
   reserved_zero_a: assert property (
      tune_reg[14] == 1'b0 && tune_reg[7:6] == 2'h0)
      else $error("reserved tune bits not zero");
   req_forced_low_a: assert property (
      switch_monitor_config |=> !req)
      else $error("switch request alive while switching disabled");
   default_src_a: assert property (
      switch_monitor_config [*3] |-> active_source_field == $past(default_source_config))
      else $error("active source not default while disabled");
   disabled_status_a: assert property (
      !ctrl.enable ##1 !ctrl.enable |-> !stat.range && !stat.lock)
      else $error("status live while self-tune off");
   irq_flag_a: assert property (
      self_tune_irq_flag |-> ctrl.enable)
      else $error("irq flag raised with tuning disabled");
   lock_pol_a: assert property (
      ctrl.enable && !stat.lock && ctrl.lock_pol |-> self_tune_irq_flag)
      else $error("lock polarity irq missing");
   range_pol_a: assert property (
      ctrl.enable && stat.range && !ctrl.range_pol |-> self_tune_irq_flag)
      else $error("range polarity irq missing");
   irq_level_a: assert property (
      |(status_reg & mask_reg) |-> irq)
      else $error("irq output low with unmasked status");
   write_resp_a: assert property (
      do_write |=> s_axi_bvalid)
      else $error("write response missing");

   // ****************************************************************
   // tuner guards
   // ****************************************************************
   // software owns trim
   sw_trim_a: assert property (
      !ctrl.enable |=> freq_trim_field == $past(sw_trim_reg))
      else $error("trim not following software value");
   idle_halt_a: assert property (
      ctrl.enable && ctrl.halt_idle && idle |=> $stable(freq_trim_field))
      else $error("trim moved while halted in idle");
   trim_frozen_a: assert property (
      ctrl.enable && stat.range |=> $stable(freq_trim_field))
      else $error("trim moved while out of range");
   trim_step_a: assert property (
      ctrl.enable |=> (freq_trim_field - $past(freq_trim_field)) inside {6'h00, 6'h01, 6'h3f}
         && !(freq_trim_field == 6'h20 && $past(freq_trim_field) == 6'h1f))
      else $error("trim stepped more than one code or wrapped");

   tune_on_c:   cover property (ctrl.enable ##[1:20] stat.lock);
   range_c:     cover property (stat.range);
   switch_c:    cover property (sw_done);
   irq_c:       cover property ($rose(irq));
   halt_c:      cover property (ctrl.halt_idle && idle && ref_tick);
endmodule

// *** bench/rc_osc_self_tune_and_switch_enable_tb.sv ***
module rc_osc_self_tune_and_switch_enable_tb
   import osc_tune_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0, rst = 1'b1;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
   logic [3:0]  s_axi_wstrb = 4'h0;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        switch_monitor_config = 1'b1, idle = 1'b0;
   logic [2:0]  default_source_config = src_low_power, active_source_field;
   logic        usb_sof_pin = 1'b0, crystal_tick_pin = 1'b0, rc_tick_pin = 1'b0;
   logic [5:0]  freq_trim_field;
   logic        self_tune_irq_flag, irq;
   int          mismatches = 0, total_checks = 0;

   osc_tune_top #(.cnt_w(16)) i_osc_tune_top (
      .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .switch_monitor_config,
      .default_source_config, .idle, .usb_sof_pin, .crystal_tick_pin, .rc_tick_pin,
      .freq_trim_field, .active_source_field, .self_tune_irq_flag, .irq);

   // 250 mhz system clock
   always #2 clk = ~clk;

   // ****************************************************************
   // bus cycles and compare
   // ****************************************************************
   // address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge clk); // gap so the next cycle never reassigns in this step
   endtask

   task automatic rd(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rdat = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge clk);
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_reset();
      rd(tune_addr);
      chk(rdat, 32'h0);
      chk({29'h0, active_source_field}, {29'h0, src_low_power});
   endtask

   // ones written to bits 14 to 0: holes and status bits must stay zero
   task automatic t_trim();
      wr(tune_addr, 32'h0000_7fff, 4'hf);
      rd(tune_addr);
      chk(rdat, 32'h0000_353f);
      chk({26'h0, freq_trim_field}, 32'h0000_003f);
   endtask

   task automatic t_tune();
      wr(tune_addr, 32'h0000_8000, 4'h2);
      wr(tune_addr, 32'h0000_8001, 4'h1);
      chk({26'h0, freq_trim_field}, 32'h0000_003f);
      // crystal reference ticks, slow enough for the pin synchroniser
      repeat (3) begin
         crystal_tick_pin <= 1'b1;
         repeat (4) @(posedge clk);
         crystal_tick_pin <= 1'b0;
         repeat (4) @(posedge clk);
      end
      rd(tune_addr);
      chk(rdat & 32'h0000_0f00, 32'h0000_0800);
      rd(status_addr);
      chk(rdat & 32'h0000_0003, 32'h0000_0001);
      wr(mask_addr, 32'h0000_0001, 4'hf);
      chk({31'h0, irq}, 32'h1);
      chk({31'h0, self_tune_irq_flag}, 32'h1);
      wr(tune_addr, 32'h0000_8400, 4'h2);
      chk({31'h0, self_tune_irq_flag}, 32'h0);
      wr(status_addr, 32'h0000_0001, 4'hf);
      chk({31'h0, irq}, 32'h0);
   endtask

   task automatic t_fixed();
      wr(control_addr, 32'h0000_0041, 4'hf);
      repeat (2) @(posedge clk);
      rd(control_addr);
      chk(rdat & 32'h0000_0701, 32'h0000_0500);
      chk({29'h0, active_source_field}, {29'h0, src_low_power});
   endtask

   task automatic t_switch();
      logic [2:0] srcs [4] = '{src_fast_rc, src_primary, src_secondary, src_low_power};
      switch_monitor_config <= 1'b0;
      @(posedge clk);
      foreach (srcs[i]) begin
         wr(control_addr, {25'h0, srcs[i], 4'h1}, 4'hf);
         repeat (2) @(posedge clk);
         chk({29'h0, active_source_field}, {29'h0, srcs[i]});
      end
      wr(control_addr, {25'h0, src_primary_pll, 4'h1}, 4'hf);
      repeat (2) @(posedge clk);
      chk({29'h0, active_source_field}, {29'h0, src_low_power});
      wr(mask_addr, 32'h0000_0004, 4'hf);
      chk({31'h0, irq}, 32'h1);
      wr(status_addr, 32'h0000_0004, 4'hf);
      chk({31'h0, irq}, 32'h0);
   endtask

   // usb frame pulses, two cycles high and two low, then settle
   task automatic sof_ticks(input int n);
      repeat (n) begin
         usb_sof_pin <= 1'b1;
         repeat (2) @(posedge clk);
         usb_sof_pin <= 1'b0;
         repeat (2) @(posedge clk);
      end
      repeat (4) @(posedge clk);
   endtask

   // frames with no rc ticks: oscillator looks slow, trim climbs to the top
   task automatic t_step();
      wr(measure_addr, 32'h0000_0002, 4'hf);
      wr(tune_addr, 32'h0000_b400, 4'h2);
      sof_ticks(2);
      chk({26'h0, freq_trim_field}, 32'h0000_0001);
      idle <= 1'b1;
      sof_ticks(2);
      chk({26'h0, freq_trim_field}, 32'h0000_0001);
      idle <= 1'b0;
      sof_ticks(32);
      chk({26'h0, freq_trim_field}, 32'h0000_001f);
      rd(tune_addr);
      chk(rdat & 32'h0000_0f3f, 32'h0000_061f);
      rd(status_addr);
      chk(rdat & 32'h0000_0003, 32'h0000_0003);
   endtask

   task automatic t_unmapped();
      wr(8'h20, 32'hffff_ffff, 4'hf);
      chk({30'h0, rsp}, {30'h0, resp_slverr});
      rd(8'h20);
      chk({30'h0, rsp}, {30'h0, resp_slverr});
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // main sequence after a twelve cycle reset
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_trim();
      t_tune();
      t_fixed();
      t_switch();
      t_step();
      t_unmapped();
      results();
   end

   // watchdog: the whole run needs well under ten thousand cycles
   initial begin
      #40000;
      mismatches++;
      results();
   end
endmodule
